// ==== logic/csc_regs.svh ====
// Register addresses, field positions, reset values and masks of the serial control block.
// Included by the top module and the test bench; holds definitions only.
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

`define CSC_PORT0_DIR_ADDR 16'hff20
`define CSC_PORT1_DIR_ADDR 16'hff21
`define CSC_PORT7_DIR_ADDR 16'hff2c
`define CSC_MODE_A_ADDR    16'hff80
`define CSC_MODE_B_ADDR    16'hff88
`define CSC_CLKSEL_A_ADDR  16'hff81
`define CSC_CLKSEL_B_ADDR  16'hff89
`define CSC_SHIFT_A_ADDR   16'hff82
`define CSC_SHIFT_B_ADDR   16'hff8a

`define CSC_DIR_RESET      8'hff
`define CSC_MODE_RESET     8'h00
`define CSC_CLKSEL_RESET   8'h00

// Writable bits; the rest read back their reset value, except mode bit 0, which reads the shifting flag
`define CSC_PORT0_WMASK    8'h63
`define CSC_PORT1_WMASK    8'hff
`define CSC_PORT7_WMASK    8'h7f
`define CSC_MODE_A_WMASK   8'hd0
`define CSC_MODE_B_WMASK   8'hf0
`define CSC_CLKSEL_WMASK   8'h1f

`define CSC_MODE_ENA_BIT   7
`define CSC_MODE_TRMD_BIT  6
`define CSC_MODE_SSE_BIT   5
`define CSC_MODE_DIR_BIT   4
`define CSC_CLKSEL_CKP_BIT 4
`define CSC_SLAVE_CODE     3'h7
`define CSC_LAST_HALF      5'h0f

// Direction bits of the serial pins
`define CSC_P1_SCK_A       0
`define CSC_P1_SO_A        2
`define CSC_P7_SO_B        4
`define CSC_P7_SCK_B       6

`endif

// ==== logic/csc_pkg.sv ====
// Types shared by the serial control block.
// Constants live in csc_regs.svh.
package csc_pkg;
    typedef enum logic [2:0] {
        CSC_DIV2   = 3'b000,
        CSC_DIV4   = 3'b001,
        CSC_DIV8   = 3'b010,
        CSC_DIV16  = 3'b011,
        CSC_DIV32  = 3'b100,
        CSC_DIV64  = 3'b101,
        CSC_DIV128 = 3'b110,
        CSC_SLAVE  = 3'b111
    } csc_div_t;

    typedef enum logic {
        CSC_IDLE  = 1'b0,
        CSC_SHIFT = 1'b1
    } csc_state_t;
endpackage

// ==== logic/csc_clk_div.sv ====
// Master serial clock divider: one tick per half period of the serial clock.
// Assumes en drops whenever the unit is disabled or not shifting.
`timescale 1ns/10ps
module csc_clk_div #(
    parameter int unsigned CNT_W = 6
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Control
    input  wire logic       en,
    input  wire logic [2:0] sel,
    // Half-period pulse
    output logic            tick
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] limit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    always_comb begin
        // Half period of 2^sel cycles gives clk / 2^(sel+1)
        limit = CNT_W'((32'h1 << sel) - 32'h1);
        tick = en && (cnt_r == limit);
        if (!en || tick) begin
            cnt_nxt = '0;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    AST_DIV_RESTART: assert property (!en |=> cnt_r == '0)
        else $error("Divider count not cleared while idle");
    AST_DIV_SPACING: assert property (tick && sel == 3'h2 |=> (!tick || !en)[*3] ##1 (tick || !en))
        else $error("Divide by 8 tick spacing wrong");
endmodule

// ==== logic/csc_top.sv ====
// Control side of two clocked three-wire serial units with port direction registers.
// Assumes single-cycle CPU byte and bit writes, pin inputs synchronous to clk.
`timescale 1ns/10ps
`include "csc_regs.svh"
module csc_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // CPU memory access
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_byte_wr,
    input  wire logic        cpu_bit_wr,
    input  wire logic [2:0]  cpu_bit_sel,
    input  wire logic        cpu_bit_val,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_rd,
    output logic [7:0]       cpu_rdata,
    // Serial pins, index 0 unit a, index 1 unit b
    input  wire logic [1:0]  sck_in,
    input  wire logic [1:0]  si_in,
    input  wire logic        chip_select_in_pin,
    input  wire logic [1:0]  sck_latch,
    input  wire logic [1:0]  so_latch,
    output logic [1:0]       sck_out,
    output logic [1:0]       sck_oe,
    output logic [1:0]       so_out,
    output logic [1:0]       so_oe,
    // Direction registers for the rest of the port logic
    output logic [7:0]       port0_dir,
    output logic [7:0]       port1_dir,
    output logic [7:0]       port7_dir
);
    localparam logic [1:0][15:0] MODE_ADDR   = {`CSC_MODE_B_ADDR, `CSC_MODE_A_ADDR};
    localparam logic [1:0][15:0] CLKSEL_ADDR = {`CSC_CLKSEL_B_ADDR, `CSC_CLKSEL_A_ADDR};
    localparam logic [1:0][15:0] SHIFT_ADDR  = {`CSC_SHIFT_B_ADDR, `CSC_SHIFT_A_ADDR};
    localparam logic [1:0][7:0]  MODE_WMASK  = {`CSC_MODE_B_WMASK, `CSC_MODE_A_WMASK};

    logic [7:0]             port0_dir_r;
    logic [7:0]             port0_dir_nxt;
    logic [7:0]             port1_dir_r;
    logic [7:0]             port1_dir_nxt;
    logic [7:0]             port7_dir_r;
    logic [7:0]             port7_dir_nxt;
    logic [1:0][7:0]        mode_r;
    logic [1:0][7:0]        mode_nxt;
    logic [1:0][7:0]        clksel_r;
    logic [1:0][7:0]        clksel_nxt;
    logic [1:0][7:0]        sh_r;
    logic [1:0][7:0]        sh_nxt;
    logic [1:0][4:0]        cnt_r;
    logic [1:0][4:0]        cnt_nxt;
    csc_pkg::csc_state_t    state_r [2];
    csc_pkg::csc_state_t    state_nxt [2];
    logic [1:0]             sck_lvl_r;
    logic [1:0]             sck_lvl_nxt;
    logic [1:0]             so_bit_r;
    logic [1:0]             so_bit_nxt;
    logic [1:0]             sck_prev_r;
    logic [1:0]             sck_out_nxt;
    logic [1:0]             sck_oe_nxt;
    logic [1:0]             so_out_nxt;
    logic [1:0]             so_oe_nxt;
    logic [7:0]             rdata_nxt;
    logic                   first_r;
    logic [1:0]             ena;
    logic [1:0]             master;
    logic [1:0]             start;
    logic [1:0]             tick;
    logic [1:0]             div_en;
    logic [1:0]             edge_ev;
    logic [1:0]             sck_dir;
    logic [1:0]             so_dir;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask, input logic hit);
        logic [7:0] nw;
        nw = old;
        if (hit && cpu_byte_wr) begin
            nw = cpu_wdata;
        end else if (hit && cpu_bit_wr) begin
            nw[cpu_bit_sel] = cpu_bit_val;
        end
        return (nw & mask) | (old & ~mask);
    endfunction

    assign sck_dir = {port7_dir_r[`CSC_P7_SCK_B], port1_dir_r[`CSC_P1_SCK_A]};
    assign so_dir  = {port7_dir_r[`CSC_P7_SO_B], port1_dir_r[`CSC_P1_SO_A]};

    for (genvar g = 0; g < 2; g++) begin : g_unit
        assign ena[g]    = mode_r[g][`CSC_MODE_ENA_BIT];
        assign master[g] = clksel_r[g][2:0] != `CSC_SLAVE_CODE;
        assign div_en[g] = ena[g] && master[g] && state_r[g] == csc_pkg::CSC_SHIFT;
        assign start[g]  = ena[g] && state_r[g] == csc_pkg::CSC_IDLE && cpu_byte_wr && cpu_addr == SHIFT_ADDR[g];
        // Slave edges are ignored while SSE is set and the chip select input is high; only unit b can set SSE
        assign edge_ev[g] = master[g] ? tick[g] :
            (sck_in[g] != sck_prev_r[g]) && !(mode_r[g][`CSC_MODE_SSE_BIT] && chip_select_in_pin);

        csc_clk_div #(.CNT_W(6)) u_div (
            .clk   (clk),
            .rst_b (rst_b),
            .en    (div_en[g]),
            .sel   (clksel_r[g][2:0]),
            .tick  (tick[g])
        );

        sequence s_start_fast;
            start[g] && clksel_r[g][2:0] == 3'h0;
        endsequence
        sequence s_idle_master;
            ena[g] && master[g] && state_r[g] == csc_pkg::CSC_IDLE && !clksel_r[g][`CSC_CLKSEL_CKP_BIT];
        endsequence

        AST_STOP_CLEARS: assert property (!ena[g] |=> state_r[g] == csc_pkg::CSC_IDLE && sh_r[g] == 8'h00)
            else $error("Disabled unit kept shift state");
        AST_STOP_PINS: assert property (!ena[g] |=> so_out[g] == $past(so_latch[g]) && sck_out[g] == $past(sck_latch[g]))
            else $error("Stopped unit still owns its pins");
        AST_OE_DIR: assert property (1'b1 |=> so_oe[g] == !$past(so_dir[g]) && sck_oe[g] == !$past(sck_dir[g]))
            else $error("Output enable does not follow direction bit");
        AST_IDLE_PHASE: assert property (s_idle_master ##1 s_idle_master |=> sck_out[g])
            else $error("Idle serial clock not high in phase type 1");
        AST_XFER_LEN: assert property (s_start_fast |-> ##16 (state_r[g] == csc_pkg::CSC_SHIFT || !ena[g])
                                       ##1 state_r[g] == csc_pkg::CSC_IDLE)
            else $error("Fastest master byte not 16 cycles");
        AST_MODE_DISABLE: assert property (cpu_byte_wr && cpu_addr == MODE_ADDR[g] && !cpu_wdata[7]
                                           |=> !ena[g] ##1 state_r[g] == csc_pkg::CSC_IDLE)
            else $error("Clearing enable did not stop the unit");
    end

    always_comb begin
        port0_dir_nxt = merge(port0_dir_r, `CSC_PORT0_WMASK, cpu_addr == `CSC_PORT0_DIR_ADDR);
        port1_dir_nxt = merge(port1_dir_r, `CSC_PORT1_WMASK, cpu_addr == `CSC_PORT1_DIR_ADDR);
        port7_dir_nxt = merge(port7_dir_r, `CSC_PORT7_WMASK, cpu_addr == `CSC_PORT7_DIR_ADDR);
        for (int i = 0; i < 2; i++) begin
            mode_nxt[i]    = merge(mode_r[i], MODE_WMASK[i], cpu_addr == MODE_ADDR[i]);
            clksel_nxt[i]  = merge(clksel_r[i], `CSC_CLKSEL_WMASK, cpu_addr == CLKSEL_ADDR[i]);
            state_nxt[i]   = state_r[i];
            sh_nxt[i]      = sh_r[i];
            cnt_nxt[i]     = cnt_r[i];
            sck_lvl_nxt[i] = sck_lvl_r[i];
            so_bit_nxt[i]  = so_bit_r[i];
            if (!ena[i]) begin
                state_nxt[i]   = csc_pkg::CSC_IDLE;
                sh_nxt[i]      = 8'h00;
                cnt_nxt[i]     = 5'h00;
                so_bit_nxt[i]  = 1'b0;
                sck_lvl_nxt[i] = !clksel_r[i][`CSC_CLKSEL_CKP_BIT];
            end else begin
                unique case (state_r[i])
                    csc_pkg::CSC_IDLE: begin
                        sck_lvl_nxt[i] = !clksel_r[i][`CSC_CLKSEL_CKP_BIT];
                        if (start[i]) begin
                            sh_nxt[i]    = cpu_wdata;
                            cnt_nxt[i]   = 5'h00;
                            state_nxt[i] = csc_pkg::CSC_SHIFT;
                        end
                    end
                    csc_pkg::CSC_SHIFT: begin
                        if (edge_ev[i]) begin
                            if (master[i]) begin
                                sck_lvl_nxt[i] = !sck_lvl_r[i];
                            end
                            // Leading edge drives data, trailing edge samples
                            if (!cnt_r[i][0]) begin
                                so_bit_nxt[i] = mode_r[i][`CSC_MODE_DIR_BIT] ? sh_r[i][0] : sh_r[i][7];
                            end else if (mode_r[i][`CSC_MODE_DIR_BIT]) begin
                                sh_nxt[i] = {si_in[i], sh_r[i][7:1]};
                            end else begin
                                sh_nxt[i] = {sh_r[i][6:0], si_in[i]};
                            end
                            cnt_nxt[i] = cnt_r[i] + 5'h01;
                            if (cnt_r[i] == `CSC_LAST_HALF) begin
                                state_nxt[i] = csc_pkg::CSC_IDLE;
                            end
                        end
                    end
                endcase
            end
            sck_out_nxt[i] = (ena[i] && master[i]) ? sck_lvl_r[i] : sck_latch[i];
            so_out_nxt[i]  = (ena[i] && mode_r[i][`CSC_MODE_TRMD_BIT]) ? so_bit_r[i] : so_latch[i];
            sck_oe_nxt[i]  = !sck_dir[i];
            so_oe_nxt[i]   = !so_dir[i];
        end
        rdata_nxt = cpu_rdata;
        if (cpu_rd) begin
            case (cpu_addr)
                `CSC_PORT0_DIR_ADDR: rdata_nxt = port0_dir_r;
                `CSC_PORT1_DIR_ADDR: rdata_nxt = port1_dir_r;
                `CSC_PORT7_DIR_ADDR: rdata_nxt = port7_dir_r;
                `CSC_MODE_A_ADDR:    rdata_nxt = {mode_r[0][7:1], state_r[0] == csc_pkg::CSC_SHIFT};
                `CSC_MODE_B_ADDR:    rdata_nxt = {mode_r[1][7:1], state_r[1] == csc_pkg::CSC_SHIFT};
                `CSC_CLKSEL_A_ADDR:  rdata_nxt = clksel_r[0];
                `CSC_CLKSEL_B_ADDR:  rdata_nxt = clksel_r[1];
                `CSC_SHIFT_A_ADDR:   rdata_nxt = sh_r[0];
                `CSC_SHIFT_B_ADDR:   rdata_nxt = sh_r[1];
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port0_dir_r <= `CSC_DIR_RESET;
            port1_dir_r <= `CSC_DIR_RESET;
            port7_dir_r <= `CSC_DIR_RESET;
            mode_r      <= {2{`CSC_MODE_RESET}};
            clksel_r    <= {2{`CSC_CLKSEL_RESET}};
            sh_r        <= '0;
            cnt_r       <= '0;
            state_r     <= '{csc_pkg::CSC_IDLE, csc_pkg::CSC_IDLE};
            sck_lvl_r   <= 2'h3;
            so_bit_r    <= 2'h0;
            // Idle-high pins: avoids a false edge right after reset
            sck_prev_r  <= 2'h3;
            sck_out     <= 2'h0;
            sck_oe      <= 2'h0;
            so_out      <= 2'h0;
            so_oe       <= 2'h0;
            cpu_rdata   <= 8'h00;
            first_r     <= 1'b0;
        end else begin
            port0_dir_r <= port0_dir_nxt;
            port1_dir_r <= port1_dir_nxt;
            port7_dir_r <= port7_dir_nxt;
            mode_r      <= mode_nxt;
            clksel_r    <= clksel_nxt;
            sh_r        <= sh_nxt;
            cnt_r       <= cnt_nxt;
            state_r     <= state_nxt;
            sck_lvl_r   <= sck_lvl_nxt;
            so_bit_r    <= so_bit_nxt;
            sck_prev_r  <= sck_in;
            sck_out     <= sck_out_nxt;
            sck_oe      <= sck_oe_nxt;
            so_out      <= so_out_nxt;
            so_oe       <= so_oe_nxt;
            cpu_rdata   <= rdata_nxt;
            first_r     <= 1'b1;
        end
    end

    assign port0_dir = port0_dir_r;
    assign port1_dir = port1_dir_r;
    assign port7_dir = port7_dir_r;

    AST_DIR_RESET: assert property (!first_r |-> port0_dir == 8'hff && port1_dir == 8'hff && port7_dir == 8'hff)
        else $error("Direction registers not all ones after reset");
    AST_MODE_RESET: assert property (!first_r |-> mode_r == 16'h0000)
        else $error("Mode registers not zero after reset");
    AST_BYTE_WR: assert property (cpu_byte_wr && cpu_addr == `CSC_PORT1_DIR_ADDR |=> port1_dir == $past(cpu_wdata))
        else $error("Byte write to port 1 direction lost");
    AST_BIT_WR: assert property (cpu_bit_wr && !cpu_byte_wr && cpu_addr == `CSC_PORT1_DIR_ADDR
                                 |=> $countones(port1_dir ^ $past(port1_dir)) <= 1)
        else $error("Bit write changed more than one bit");
endmodule

// ==== bench/csc_periph.sv ====
// Peripheral on the serial lines of unit a: MSB first, shifts out on falling, captures on rising.
// Assumes sck is the pin level with its pull-up, and load pulses before every byte.
`timescale 1ns/10ps
module csc_periph (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Serial lines
    input  wire logic       sck,
    input  wire logic       sdi,
    output logic            sdo,
    // Bench side
    input  wire logic       load,
    input  wire logic [7:0] tx,
    output logic [7:0]      rx
);
    logic       sck_r;
    logic [3:0] cnt_r;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_r <= 1'b1;
            cnt_r <= 4'h8;
            sdo   <= 1'b0;
            rx    <= 8'h00;
        end else begin
            sck_r <= sck;
            if (load) begin
                cnt_r <= 4'h0;
            end else if (sck_r && !sck && cnt_r < 4'h8) begin
                sdo <= tx[3'h7 - cnt_r[2:0]];
            end else if (!sck_r && sck && cnt_r < 4'h8) begin
                rx    <= {rx[6:0], sdi};
                cnt_r <= cnt_r + 4'h1;
            end else if (cnt_r == 4'h8) begin
                // Released line: never shows a stale bit
                sdo <= ~sdo;
            end
        end
    end
endmodule

// ==== bench/csi_stop_mode_and_clock_select_test.sv ====
// Self-checking bench: register defaults, direction pins, master divider codes, slave, disable.
// Assumes the peripheral model sits on unit a and the bench plays the slave clock of unit b.
`timescale 1ns/10ps
`include "csc_regs.svh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin fail_count++; \
    $display("FAIL %s expected %h seen %h", nm, ex, gt); end end
module csi_stop_mode_and_clock_select_test;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic        cpu_byte_wr = 1'b0;
    logic        cpu_bit_wr = 1'b0;
    logic [2:0]  cpu_bit_sel = 3'h0;
    logic        cpu_bit_val = 1'b0;
    logic [7:0]  cpu_wdata = 8'h00;
    logic        cpu_rd = 1'b0;
    logic [7:0]  cpu_rdata;
    logic        sck_b = 1'b1;
    logic        si_b = 1'b0;
    logic [1:0]  sck_latch = 2'h3;
    logic [1:0]  so_latch = 2'h0;
    logic [1:0]  sck_out, sck_oe, so_out, so_oe;
    logic [7:0]  port0_dir, port1_dir, port7_dir;
    logic        p_sdo;
    logic        p_load = 1'b0;
    logic [7:0]  p_tx = 8'h00;
    logic [7:0]  p_rx, v;
    logic [7:0]  vs [3];
    int          fail_count = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          seed = 32'hcca7;
    wire         sck_a = sck_oe[0] ? sck_out[0] : 1'b1;
    logic [15:0] ra [8] = '{16'hff20, 16'hff21, 16'hff2c, 16'hff80, 16'hff88, 16'hff81, 16'hff89, 16'h1234};
    logic [7:0]  rv [8] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  dm [3] = '{`CSC_PORT0_WMASK, `CSC_PORT1_WMASK, `CSC_PORT7_WMASK};

    csc_top i_csc_top (.clk(clk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_byte_wr(cpu_byte_wr),
        .cpu_bit_wr(cpu_bit_wr), .cpu_bit_sel(cpu_bit_sel), .cpu_bit_val(cpu_bit_val),
        .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .sck_in({sck_b, 1'b1}),
        .si_in({si_b, p_sdo}), .chip_select_in_pin(1'b0), .sck_latch(sck_latch), .so_latch(so_latch),
        .sck_out(sck_out), .sck_oe(sck_oe), .so_out(so_out), .so_oe(so_oe), .port0_dir(port0_dir),
        .port1_dir(port1_dir), .port7_dir(port7_dir));
    csc_periph i_csc_periph (.clk(clk), .rst_b(rst_b), .sck(sck_a), .sdi(so_out[0]), .sdo(p_sdo),
        .load(p_load), .tx(p_tx), .rx(p_rx));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            summarize();
        end
    end

    function automatic logic [7:0] rnd();
        int t;
        t = $random(seed);
        return t[7:0];
    endfunction
    function automatic logic [7:0] ord(input logic [7:0] x, input logic d);
        return d ? {x[0], x[1], x[2], x[3], x[4], x[5], x[6], x[7]} : x;
    endfunction
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr    <= a;
        cpu_wdata   <= d;
        cpu_byte_wr <= 1'b1;
        @(posedge clk);
        cpu_byte_wr <= 1'b0;
    endtask
    task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic b);
        @(posedge clk);
        cpu_addr    <= a;
        cpu_bit_sel <= s;
        cpu_bit_val <= b;
        cpu_bit_wr  <= 1'b1;
        @(posedge clk);
        cpu_bit_wr  <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_rd   <= 1'b1;
        @(posedge clk);
        cpu_rd   <= 1'b0;
        @(posedge clk);
        #1 d = cpu_rdata;
    endtask
    task automatic chkrd(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] r;
        rd(a, r);
        `CHK("cpu_rdata", e, r)
    endtask

    // Master byte on unit a; clock select only touched while disabled
    task automatic mst(input logic [2:0] c);
        int n;
        logic [7:0] tx;
        logic [7:0] r;
        tx = rnd();
        bw(`CSC_MODE_A_ADDR, 3'h7, 1'b0);
        wr(`CSC_CLKSEL_A_ADDR, {5'h00, c});
        bw(`CSC_MODE_A_ADDR, 3'h7, 1'b1);
        p_tx   <= rnd();
        p_load <= 1'b1;
        @(posedge clk);
        p_load <= 1'b0;
        wr(`CSC_SHIFT_A_ADDR, tx);
        n = 0;
        while (sck_out[0] !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (sck_out[0] === 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        `CHK("sck low half", 1 << c, n)
        r = 8'h01;
        for (int i = 0; i < 600 && r[0] !== 1'b0; i++) rd(`CSC_MODE_A_ADDR, r);
        `CHK("mode_a", 8'hc0, r)
        // Slow partner cannot follow the two fastest codes
        if (c >= 3'h2) begin
            `CHK("peripheral rx", tx, p_rx)
            chkrd(`CSC_SHIFT_A_ADDR, p_tx);
        end
    endtask

    // Slave byte on unit b with the bench making the clock
    task automatic slv(input logic d);
        logic [7:0] tx, sn, s, cap;
        tx  = rnd();
        sn  = rnd();
        s   = ord(sn, d);
        cap = 8'h00;
        wr(`CSC_MODE_B_ADDR, {3'b110, d, 4'h0});
        wr(`CSC_SHIFT_B_ADDR, tx);
        for (int i = 7; i >= 0; i--) begin
            repeat (3) @(posedge clk);
            sck_b <= 1'b0;
            si_b  <= s[i];
            repeat (4) @(posedge clk);
            @(negedge clk);
            cap = {cap[6:0], so_out[1]};
            @(posedge clk);
            sck_b <= 1'b1;
        end
        repeat (6) @(posedge clk);
        #1 `CHK("sck_oe b", 1'b0, sck_oe[1])
        `CHK("so bits", tx, ord(cap, d))
        chkrd(`CSC_SHIFT_B_ADDR, sn);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wr(16'h1234, rnd());
        for (int i = 0; i < 8; i++) chkrd(ra[i], rv[i]);
        // Stopped units show the port latches
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            @(posedge clk);
            sck_latch <= v[1:0];
            so_latch  <= v[3:2];
            repeat (3) @(posedge clk);
            #1 `CHK("stopped pins", {v[1:0], v[3:2]}, {sck_out, so_out})
        end
        for (int i = 0; i < 3; i++) begin
            vs[i] = rnd();
            wr(ra[i], vs[i]);
            chkrd(ra[i], (vs[i] & dm[i]) | ~dm[i]);
        end
        `CHK("pin enables", ~{vs[2][6], vs[1][0], vs[2][4], vs[1][2]}, {sck_oe, so_oe})
        `CHK("dir outputs", {(vs[0] & dm[0]) | ~dm[0], vs[1], vs[2] | 8'h80}, {port0_dir, port1_dir, port7_dir})
        bw(`CSC_PORT0_DIR_ADDR, 3'h3, 1'b0);
        chkrd(`CSC_PORT0_DIR_ADDR, (vs[0] & dm[0]) | ~dm[0]);
        bw(`CSC_PORT1_DIR_ADDR, 3'h0, 1'b0);
        bw(`CSC_PORT1_DIR_ADDR, 3'h2, 1'b0);
        chkrd(`CSC_PORT1_DIR_ADDR, vs[1] & 8'hfa);
        wr(`CSC_PORT7_DIR_ADDR, 8'hef);
        wr(`CSC_MODE_B_ADDR, 8'h3f);
        chkrd(`CSC_MODE_B_ADDR, 8'h30);
        @(posedge clk);
        sck_latch <= 2'h3;
        so_latch  <= 2'h0;
        wr(`CSC_MODE_A_ADDR, 8'hef);
        chkrd(`CSC_MODE_A_ADDR, 8'hc0);
        #1 `CHK("sck idle", 1'b1, sck_out[0])
        // Inverted phase idles low; next mst restores the default
        bw(`CSC_MODE_A_ADDR, 3'h7, 1'b0);
        wr(`CSC_CLKSEL_A_ADDR, 8'h10);
        bw(`CSC_MODE_A_ADDR, 3'h7, 1'b1);
        repeat (3) @(posedge clk);
        #1 `CHK("sck idle inverted", 1'b0, sck_out[0])
        for (int c = 0; c < 7; c++) mst(c[2:0]);
        // Disable in mid byte
        bw(`CSC_MODE_A_ADDR, 3'h7, 1'b0);
        wr(`CSC_CLKSEL_A_ADDR, 8'h06);
        bw(`CSC_MODE_A_ADDR, 3'h7, 1'b1);
        wr(`CSC_SHIFT_A_ADDR, 8'h5a);
        repeat (200) @(posedge clk);
        sck_latch <= 2'h2;
        so_latch  <= 2'h1;
        bw(`CSC_MODE_A_ADDR, 3'h7, 1'b0);
        chkrd(`CSC_MODE_A_ADDR, 8'h40);
        chkrd(`CSC_SHIFT_A_ADDR, 8'h00);
        repeat (100) @(posedge clk);
        #1 `CHK("released a", 2'b01, {sck_out[0], so_out[0]})
        @(posedge clk);
        sck_latch <= 2'h3;
        so_latch  <= 2'h0;
        mst(3'h6);
        wr(`CSC_CLKSEL_B_ADDR, {5'h00, `CSC_SLAVE_CODE});
        slv(1'b0);
        slv(1'b1);
        // Reset in mid run must restore every default
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) chkrd(ra[i], rv[i]);
        #1 `CHK("pin enables after reset", 4'h0, {sck_oe, so_oe})
        summarize();
    end
endmodule
